//--- verilog/clock_gating_and_pll_control.v
// Purpose: clock gating, clock output pin and PLL control
// Assumes: inputs synchronous to clk_in; classic Wishbone slave
// Notes:   derived clocks are square waves made from clk_in;
//          lock and deselect waits of the PLL are left to software
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_defines.vh"

module clock_gating_and_pll_control (
   // clock and reset
   input  wire       clk_in,
   input  wire       rst_in,
   // wishbone slave
   input  wire       wb_cyc_in,
   input  wire       wb_stb_in,
   input  wire       wb_we_in,
   input  wire [3:0] wb_adr_in,
   input  wire [3:0] wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output reg  [31:0] wb_dat_out,
   output reg        wb_ack_out,
   // operating mode and subclock oscillator
   input  wire [2:0] op_mode_in,
   input  wire       subclock_in,
   // clock enables and gated clocks
   output reg        main_osc_run_out,
   output reg        cpu_clk_out,
   output reg        sys_clk_out,
   output reg        periph_clk_out,
   output reg        second_watchdog_run_out,
   // oscillator and PLL controls
   output reg        feedback_resistor_off_out,
   output reg        pll_run_out,
   output reg        pll_x4_out,
   // clock output pin
   output reg        clock_output_pin_out,
   output reg        clock_output_pin_oe_out
);

   // software registers
   reg  [7:0]  proc_clk_ctrl_reg;
   reg  [7:0]  pll_control_reg;
   reg  [7:0]  port_cm_mode_reg;
   reg         clock_source_status_reg;

   // clock generation state
   reg  [1:0]  prescale_reg;
   reg  [7:0]  div_count_reg;
   reg         sub_prev_reg;

   // decoded state
   wire        bus_req;
   wire        bus_wr;
   wire        main_stop_bit;
   wire        subclock_select;
   wire [2:0]  system_clock_divide;
   wire        pll_run;
   wire        pll_select;
   wire        pll_x4_now;
   wire        half_tick;
   wire        sub_rise;
   wire        main_osc_on;
   wire        in_normal;
   wire        in_stab;
   wire        in_halt;
   wire        in_idle;
   wire        in_stop;
   wire        cpu_en;
   wire        sys_en;
   wire        periph_en;
   wire        sys_phase;
   wire        main_phase;
   wire        cpu_gated;
   wire        sys_gated;
   wire        periph_gated;
   wire        pin_gated;
   reg  [7:0]  rd_byte;
   wire        chain_run;
   wire        periph_phase;
   wire        pin_select;
   wire        pin_en;

   // limitations a user must know:
   // - a mode code above STOP stops every derived clock; only the watchdog runs
   // - after an oscillator stop the divider steps on until the gate phases are
   //   low, so no derived clock is frozen in its high phase
   // - the source switch happens at a subclock rise; the old source may end
   //   with one short phase at that moment
   // - sel lanes above lane 0 and data above bit 7 are ignored

   // request decode: one ack per access, write at the acking edge
   // a strobe held past the ack starts a new access once the ack has dropped
   assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign bus_wr  = bus_req & wb_we_in & wb_sel_in[0];

   // register fields
   assign system_clock_divide = proc_clk_ctrl_reg[`PCC_DIV_MSB:`PCC_DIV_LSB];
   assign subclock_select     = proc_clk_ctrl_reg[`PCC_SUB_SEL_BIT];
   assign main_stop_bit       = proc_clk_ctrl_reg[`PCC_MAIN_STOP_BIT];
   assign pll_run             = pll_control_reg[`PLL_RUN_BIT];
   assign pll_select          = pll_control_reg[`PLL_SEL_BIT];

   // mode decode
   // codes above STOP decode to none of these, so only the watchdog runs on them
   assign in_normal = (op_mode_in == `MODE_NORMAL);
   assign in_stab   = (op_mode_in == `MODE_STAB);
   assign in_halt   = (op_mode_in == `MODE_HALT);
   assign in_idle   = (op_mode_in == `MODE_IDLE);
   assign in_stop   = (op_mode_in == `MODE_STOP);

   // main oscillator stop
   // stab, HALT, IDLE keep it; STOP and the main stop bit end it
   assign main_osc_on = ~in_stop & ~main_stop_bit &
                        (in_normal | in_stab | in_halt | in_idle);

   // four times when selected
   // the multiplier only counts once the loop is running as well
   assign pll_x4_now = pll_select & pll_run & main_osc_on;

   // oscillator half period
   // through mode keeps the oscillator rate, a quarter of PLL rate
   assign half_tick = pll_x4_now | (prescale_reg == `THROUGH_HALF_CYCLES);

   // divider chain runs on after an oscillator stop until both gate phases
   // are low; freezing it in a high phase would leave the gated clocks high
   assign periph_phase = div_count_reg[0];
   assign chain_run    = main_osc_on | main_phase | periph_phase;

   // prescaler and divider chain for the main clock
   always @(posedge clk_in) begin
      if (rst_in) begin
         prescale_reg  <= 2'h0;
         div_count_reg <= 8'h00;
      end else if (chain_run) begin
         prescale_reg <= prescale_reg + 2'h1;
         if (half_tick) begin
            prescale_reg  <= 2'h0;
            div_count_reg <= div_count_reg + 8'h01;
         end
      end
   end

   // divide select
   // bit n of the chain is the oscillator clock divided by 2^n
   assign main_phase = div_count_reg[system_clock_divide];

   // subclock edge for the source switch
   always @(posedge clk_in) begin
      if (rst_in) begin
         sub_prev_reg <= 1'b0;
      end else begin
         sub_prev_reg <= subclock_in;
      end
   end
   assign sub_rise = subclock_in & ~sub_prev_reg;

   // source switch
   // the new source is taken on the next subclock rise, so within one period
   always @(posedge clk_in) begin
      if (rst_in) begin
         clock_source_status_reg <= 1'b0;
      end else if (sub_rise) begin
         clock_source_status_reg <= subclock_select;
      end
   end

   // system clock comes from the subclock once the switch has happened
   assign sys_phase = clock_source_status_reg ? subclock_in : main_phase;

   // system clock enable
   // runs in normal and HALT from a running source; off in IDLE, STOP, stab
   assign sys_en = (in_normal | in_halt) & (clock_source_status_reg | main_osc_on);

   // CPU clock stops in HALT as well
   assign cpu_en = in_normal & (clock_source_status_reg | main_osc_on);

   // peripheral clock enable
   // needs the main oscillator, so the main stop bit kills it too
   assign periph_en = (in_normal | in_halt) & main_osc_on;

   // gated derived clocks
   // cpu and system gates share the phase and differ only in their enable
   clock_gate_cell cpu_gate (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .phase_in  (sys_phase),
      .enable_in (cpu_en),
      .gated_out (cpu_gated)
   );

   clock_gate_cell sys_gate (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .phase_in  (sys_phase),
      .enable_in (sys_en),
      .gated_out (sys_gated)
   );

   // peripheral gate on the undivided oscillator clock
   clock_gate_cell periph_gate (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .phase_in  (periph_phase),
      .enable_in (periph_en),
      .gated_out (periph_gated)
   );

   // pin select waits for a low phase
   // the select goes through the gate, so turning the pin on gives no runt
   assign pin_select = port_cm_mode_reg[`PORT_CM_CLK_BIT];
   assign pin_en     = sys_en & pin_select;

   // pin gate has its own cell so pin selection also waits for a low phase
   clock_gate_cell pin_gate (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .phase_in  (sys_phase),
      .enable_in (pin_en),
      .gated_out (pin_gated)
   );

   // register writes; bit-level software access is a byte read-modify-write
   always @(posedge clk_in) begin
      if (rst_in) begin
         proc_clk_ctrl_reg <= `PCC_RESET;
         pll_control_reg   <= `PLL_RESET;
         port_cm_mode_reg  <= `PORT_CM_RESET;
      end else if (bus_wr) begin
         case (wb_adr_in)
            `OFS_PROC_CLK_CTRL: begin
               // status bit is read only and not stored here
               proc_clk_ctrl_reg <= wb_dat_in[7:0] & 8'h6F;
            end
            `OFS_PLL_CONTROL: begin
               pll_control_reg <= wb_dat_in[7:0] & 8'h03;
            end
            `OFS_PORT_CM_MODE: begin
               port_cm_mode_reg <= wb_dat_in[7:0] & 8'h02;
            end
            default: begin
               proc_clk_ctrl_reg <= proc_clk_ctrl_reg;
            end
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always @* begin
      rd_byte = 8'h00;
      case (wb_adr_in)
         `OFS_PROC_CLK_CTRL: begin
            rd_byte = proc_clk_ctrl_reg;
            // status is the live source flag, not a stored copy
            rd_byte[`PCC_STATUS_BIT] = clock_source_status_reg;
         end
         `OFS_PLL_CONTROL: begin
            rd_byte = pll_control_reg;
         end
         `OFS_PORT_CM_MODE: begin
            rd_byte = port_cm_mode_reg;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // bus answer: ack one cycle after the request, dropped the cycle after
   always @(posedge clk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         // a read takes the register as it stands at the taking edge
         wb_ack_out <= bus_req;
         if (bus_req) begin
            wb_dat_out <= {24'h000000, rd_byte};
         end
      end
   end

   // level outputs toward oscillators, PLL and watchdog
   always @(posedge clk_in) begin
      if (rst_in) begin
         main_osc_run_out          <= 1'b0;
         second_watchdog_run_out   <= 1'b0;
         feedback_resistor_off_out <= 1'b0;
         pll_run_out               <= 1'b0;
         pll_x4_out                <= 1'b0;
      end else begin
         main_osc_run_out <= main_osc_on;
         // watchdog runs after reset
         // kept even in STOP and all subclock states
         second_watchdog_run_out <= 1'b1;
         // external clock drive
         // the bit only drops the resistor; the stab mode still comes first
         feedback_resistor_off_out <= proc_clk_ctrl_reg[`PCC_FB_OFF_BIT];
         // PLL runs in IDLE
         // only an oscillator stop forces it off, so STOP stops it without software
         pll_run_out <= pll_run & main_osc_on;
         pll_x4_out  <= pll_x4_now;
      end
   end

   // gated clocks out, one more flop so every output is registered
   // the extra flop keeps the gate lag equal on all three clock outputs
   always @(posedge clk_in) begin
      if (rst_in) begin
         cpu_clk_out    <= 1'b0;
         sys_clk_out    <= 1'b0;
         periph_clk_out <= 1'b0;
      end else begin
         cpu_clk_out    <= cpu_gated;
         sys_clk_out    <= sys_gated;
         periph_clk_out <= periph_gated;
      end
   end

   // clock output pin
   always @(posedge clk_in) begin
      if (rst_in) begin
         clock_output_pin_out    <= 1'b0;
         clock_output_pin_oe_out <= 1'b0;
      end else begin
         clock_output_pin_oe_out <= port_cm_mode_reg[`PORT_CM_CLK_BIT];
         // pin follows clock
         // a stopped system clock leaves the gate low, so the pin sits low
         clock_output_pin_out <= pin_gated & port_cm_mode_reg[`PORT_CM_CLK_BIT];
      end
   end

endmodule // clock_gating_and_pll_control
`default_nettype wire

//--- verilog/clock_control_defines.vh
// What this block does
// - main oscillator stops in reset, STOP, main-stop
// - system clock runs in normal, HALT, subclock only
// - peripheral clocks need main oscillator, normal/HALT
// - second watchdog clock stops only in reset
// - output pin follows system clock, else low
// - pin floats after reset until selected
// - pin frequency follows system clock divide bits
// - external clock: resistor off, wait kept
// - PLL mode four times, through mode unchanged
// - eight-bit PLL control: run bit0, select bit1
// - PLL control resets to 01H
// - PLL may keep running during IDLE
// - pin is clock output only when selected
// - source switch within one subclock period, status
//
// Purpose: constants of the clock controller
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef CLOCK_CONTROL_DEFINES_VH
`define CLOCK_CONTROL_DEFINES_VH

// register byte offsets on the bus
`define OFS_PROC_CLK_CTRL     4'h0
`define OFS_PLL_CONTROL       4'h4
`define OFS_PORT_CM_MODE      4'h8

// processor clock control fields
`define PCC_DIV_LSB           0
`define PCC_DIV_MSB           2
`define PCC_SUB_SEL_BIT       3
`define PCC_STATUS_BIT        4
`define PCC_FB_OFF_BIT        5
`define PCC_MAIN_STOP_BIT     6
`define PCC_RESET             8'h03

// PLL control fields
`define PLL_RUN_BIT           0
`define PLL_SEL_BIT           1
`define PLL_RESET             8'h01

// port CM mode: bit 1 selects the clock output function
`define PORT_CM_CLK_BIT       1
`define PORT_CM_RESET         8'h00

// operating mode codes from the power controller
`define MODE_NORMAL           3'h0
`define MODE_STAB             3'h1
`define MODE_HALT             3'h2
`define MODE_IDLE             3'h3
`define MODE_STOP             3'h4

// oscillator half period in through mode, less one, in clk_in cycles
`define THROUGH_HALF_CYCLES   2'h3

`endif

//--- verilog/clock_gate_cell.v
// Purpose: glitch-free gate for one derived clock
// Assumes: phase_in is a square wave made in the clk_in domain
// Notes:   the enable is only taken while the phase is low
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_defines.vh"

module clock_gate_cell (
   // clock and reset
   input  wire clk_in,
   input  wire rst_in,
   // phase and enable
   input  wire phase_in,
   input  wire enable_in,
   // gated clock
   output reg  gated_out
);

   reg enable_reg;

   always @(posedge clk_in) begin
      if (rst_in) begin
         enable_reg <= 1'b0;
         gated_out  <= 1'b0;
      end else begin
         if (!phase_in) begin
            enable_reg <= enable_in;
         end
         // a high phase keeps the enable it started with, so no runt pulse
         gated_out <= phase_in & enable_reg;
      end
   end

endmodule // clock_gate_cell
`default_nettype wire

//--- bench/clock_gating_and_pll_control_properties.sv
// Purpose: port-level checks of the clock controller
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the top module below
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_defines.vh"
module clock_control_checker (
   // clock, reset and bus
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   // mode and clock outputs
   input wire logic [2:0]  op_mode_in,
   input wire logic        main_osc_run_out,
   input wire logic        cpu_clk_out,
   input wire logic        sys_clk_out,
   input wire logic        periph_clk_out,
   input wire logic        second_watchdog_run_out,
   input wire logic        pll_run_out,
   input wire logic        pll_x4_out,
   input wire logic        clock_output_pin_out,
   input wire logic        clock_output_pin_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic [9:0] off_cnt;
   // cycles spent in idle or stop; 600 covers the slowest low phase
   always_ff @(posedge clk_in) begin
      if (rst_in || !(op_mode_in == `MODE_IDLE || op_mode_in == `MODE_STOP)) off_cnt <= 10'h000;
      else if (off_cnt != 10'h3FF) off_cnt <= off_cnt + 10'h001;
   end
   a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack one cycle after request");
   a_read_upper_zero: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h000000)
      else $error("read data above byte not zero");
   a_watchdog_runs: assert property (!rst_in |=> second_watchdog_run_out)
      else $error("watchdog clock stopped outside reset");
   a_stop_osc_off: assert property (op_mode_in == `MODE_STOP |=> !main_osc_run_out)
      else $error("main oscillator runs in stop");
   a_idle_clocks_off: assert property (off_cnt >= 10'd600 |-> !sys_clk_out && !cpu_clk_out && !periph_clk_out)
      else $error("clock still running in idle or stop");
   a_pin_low_float: assert property (!clock_output_pin_oe_out |-> !clock_output_pin_out)
      else $error("pin driven while not selected");
   a_pll_needs_run: assert property (pll_x4_out |-> pll_run_out && main_osc_run_out)
      else $error("multiplying without pll running");
   c_read: cover property (wb_ack_out && !wb_we_in);
   c_pll_x4: cover property (pll_x4_out);
   c_pin_out: cover property (clock_output_pin_oe_out && $rose(clock_output_pin_out));
endmodule // clock_control_checker
bind clock_gating_and_pll_control clock_control_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .op_mode_in(op_mode_in), .main_osc_run_out(main_osc_run_out),
   .cpu_clk_out(cpu_clk_out), .sys_clk_out(sys_clk_out), .periph_clk_out(periph_clk_out),
   .second_watchdog_run_out(second_watchdog_run_out), .pll_run_out(pll_run_out), .pll_x4_out(pll_x4_out),
   .clock_output_pin_out(clock_output_pin_out), .clock_output_pin_oe_out(clock_output_pin_oe_out));
`default_nettype wire

//--- bench/subclock_osc_model.sv
// Purpose: subclock oscillator on the far side
// Assumes: square wave made in the clk_in domain
// Notes:   runs free in every state, reset included
`timescale 1ns/10ps
`default_nettype none
module subclock_osc_model #(parameter int HALF = 40) (
   // clock
   input  wire logic clk_in,
   // subclock wave
   output var  logic subclock_out
);
   int cnt = 0;
   initial subclock_out = 1'b0;
   // free running: never stopped, so switching is always possible
   always @(posedge clk_in) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) subclock_out <= ~subclock_out;
   end
endmodule // subclock_osc_model
`default_nettype wire

//--- bench/clock_gating_and_pll_control_tb_top.sv
// Purpose: register and clock gating tests of the clock controller
// Assumes: 250 MHz clk_in, ack one cycle after request
// Notes:   periods measured in clk_in cycles on rising edges
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_defines.vh"
module clock_gating_and_pll_control_tb_top;
   logic clk_in = 0, rst_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, subclock_in;
   logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic [2:0] op_mode_in = `MODE_NORMAL;
   logic wb_ack_out, main_osc_run_out, cpu_clk_out, sys_clk_out, periph_clk_out, second_watchdog_run_out;
   logic feedback_resistor_off_out, pll_run_out, pll_x4_out, clock_output_pin_out, clock_output_pin_oe_out;
   int num_errors = 0, check_count = 0, p, n;
   always #2 clk_in = ~clk_in;
   subclock_osc_model u_sub (.clk_in(clk_in), .subclock_out(subclock_in));
   clock_gating_and_pll_control dut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
      .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .op_mode_in(op_mode_in),
      .subclock_in(subclock_in), .main_osc_run_out(main_osc_run_out), .cpu_clk_out(cpu_clk_out),
      .sys_clk_out(sys_clk_out), .periph_clk_out(periph_clk_out),
      .second_watchdog_run_out(second_watchdog_run_out), .feedback_resistor_off_out(feedback_resistor_off_out),
      .pll_run_out(pll_run_out), .pll_x4_out(pll_x4_out), .clock_output_pin_out(clock_output_pin_out),
      .clock_output_pin_oe_out(clock_output_pin_oe_out));
   task automatic report_and_stop;
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one classic cycle; held until ack is sampled high
   task automatic bus(input logic [3:0] a, input logic we, input logic [3:0] sel, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk_in);
      wb_cyc_in <= 1'b1; wb_stb_in <= 1'b1; wb_we_in <= we; wb_adr_in <= a; wb_sel_in <= sel;
      wb_dat_in <= {24'h000000, d};
      do begin @(posedge clk_in); k++; end while (wb_ack_out !== 1'b1 && k < 100);
      if (k >= 100) chk("ack", 32'h1, 32'h0);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0; wb_stb_in <= 1'b0; wb_we_in <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d); bus(a, 1'b1, 4'h1, d); endtask
   task automatic rd(input string name, input logic [3:0] a, input logic [7:0] e);
      bus(a, 1'b0, 4'h1, 8'h00); chk(name, {24'h000000, e}, q);
   endtask
   // cycles between two rising edges of the clock output chosen by which
   // which: 0 system clock, 1 pin, 2 cpu clock, 3 peripheral clock
   task automatic period(input int which, output int pr);
      int k, r; logic v, pv;
      k = 0; r = 0; pr = 0; pv = 1'b1;
      while (r < 2 && k < 4000) begin
         @(posedge clk_in);
         v = (which == 1) ? clock_output_pin_out : (which == 2) ? cpu_clk_out :
             (which == 3) ? periph_clk_out : sys_clk_out;
         if (v === 1'b1 && pv === 1'b0) r++;
         if (r == 1) pr++;
         pv = v; k++;
      end
   endtask
   task automatic settle_period(input int which); period(which, p); period(which, p); endtask
   // hang guard, well beyond the longest sequence
   initial begin #400000; num_errors++; report_and_stop; end
   initial begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk("pin_oe", 32'h0, {31'h0, clock_output_pin_oe_out});
      chk("wdt", 32'h1, {31'h0, second_watchdog_run_out});
      rd("pll_reset", `OFS_PLL_CONTROL, `PLL_RESET);
      rd("pcc_reset", `OFS_PROC_CLK_CTRL, `PCC_RESET);
      rd("portcm_reset", `OFS_PORT_CM_MODE, `PORT_CM_RESET);
      rd("unmapped", 4'hC, 8'h00);
      bus(`OFS_PLL_CONTROL, 1'b1, 4'h0, 8'h00);
      rd("pll_nosel", `OFS_PLL_CONTROL, 8'h01);
      for (n = 0; n < 4; n++) begin
         wr(`OFS_PROC_CLK_CTRL, n[7:0]);
         settle_period(0); chk("through_period", 8 << n, p);
      end
      settle_period(2); chk("cpu_period", 32'd64, p);
      settle_period(3); chk("periph_period", 32'd8, p);
      wr(`OFS_PORT_CM_MODE, 8'h02);
      repeat (3) @(posedge clk_in);
      chk("pin_oe_sel", 32'h1, {31'h0, clock_output_pin_oe_out});
      settle_period(1); chk("pin_period", 32'd64, p);
      // lock wait of 200 us before selecting the multiplier
      repeat (50000) @(posedge clk_in);
      wr(`OFS_PLL_CONTROL, 8'h03);
      settle_period(0); chk("pll_period", 32'd16, p);
      chk("pll_x4", 32'h1, {31'h0, pll_x4_out});
      wr(`OFS_PLL_CONTROL, 8'h01);
      repeat (8) @(posedge clk_in);
      wr(`OFS_PLL_CONTROL, 8'h00);
      repeat (2) @(posedge clk_in);
      chk("pll_run_off", 32'h0, {31'h0, pll_run_out});
      op_mode_in <= `MODE_IDLE; repeat (700) @(posedge clk_in);
      chk("idle_sys", 32'h0, {31'h0, sys_clk_out});
      chk("idle_pin", 32'h0, {31'h0, clock_output_pin_out});
      chk("idle_osc", 32'h1, {31'h0, main_osc_run_out});
      wr(`OFS_PLL_CONTROL, 8'h01); repeat (2) @(posedge clk_in);
      chk("idle_pll", 32'h1, {31'h0, pll_run_out});
      wr(`OFS_PLL_CONTROL, 8'h00);
      op_mode_in <= `MODE_HALT;
      settle_period(0); chk("halt_period", 32'd64, p);
      chk("halt_cpu", 32'h0, {31'h0, cpu_clk_out});
      op_mode_in <= `MODE_STOP; repeat (700) @(posedge clk_in);
      chk("stop_osc", 32'h0, {31'h0, main_osc_run_out});
      chk("stop_wdt", 32'h1, {31'h0, second_watchdog_run_out});
      op_mode_in <= `MODE_NORMAL;
      wr(`OFS_PROC_CLK_CTRL, 8'h23); repeat (2) @(posedge clk_in);
      chk("fb_off", 32'h1, {31'h0, feedback_resistor_off_out});
      wr(`OFS_PROC_CLK_CTRL, 8'h2B);
      // status must follow within one subclock period of 80 cycles
      n = 0;
      do begin bus(`OFS_PROC_CLK_CTRL, 1'b0, 4'h1, 8'h00); n++; end while (q[4] !== 1'b1 && n < 30);
      chk("status_sub", 32'h3B, q);
      wr(`OFS_PROC_CLK_CTRL, 8'h6B); repeat (700) @(posedge clk_in);
      chk("mstop_osc", 32'h0, {31'h0, main_osc_run_out});
      chk("mstop_periph", 32'h0, {31'h0, periph_clk_out});
      settle_period(0); chk("sub_period", 32'd80, p);
      settle_period(2); chk("sub_cpu_period", 32'd80, p);
      report_and_stop;
   end
endmodule // clock_gating_and_pll_control_tb_top
`default_nettype wire
